// >>> logic/dbg_engine.sv
// instruction layer and turnaround control of the single-pin debug port
// Function
// R1: guard idle bits precede every transmit after receive; count from field.
// R2: each guard idle bit lasts one current bit period.
// R3: software should avoid guard setting seven, which adds no idle bits.
// R4: transmit waits for both guard and system access, whichever ends later.
// R5: each one-byte instruction is preceded by a sync character.
// R6: direct load takes address bytes, returns data after guard.
// R7: repeated direct load takes a fresh address each time, no increment.
// R8: direct store acks address, then acks data after bus write.
// R9: indirect load reads at pointer, may post-increment, or returns it.
// R10: indirect store in pointer-write mode loads pointer, then acknowledges.
// R11: indirect store mode zero keeps pointer, mode one advances by size.
// R12: indirect store acknowledges only after the bus write succeeds.
// R13: control/status load uses opcode address, returns one byte after guard.
// R14: control/status store takes one byte, sends nothing back.
// R15: repeat loads one count byte; repeat itself is never repeated.
// R16: instruction after repeat runs count plus one times.
// R17: repeated iterations carry operands only, store acks kept.
// R18: only a break ends a repeat early.
// R19: pointer access without increment repeats on the same address.
// R20: key takes eight bytes and sends no answer.
// R21: key with info select sends system info block after guard.
// R22: any error enters a state ignoring traffic until a break.
// R23: the sync character has the fixed value 0x55.
// R24: opcode in bits 7:5, sizes or pointer mode in 3:0.
// R25: reserved size codes are errors and cause no bus access.
`timescale 1ns/1ns
module dbg_engine #(
   parameter int           BPW      = 16,
   parameter logic [127:0] SIB_DATA = 128'h0 // arbitrary value
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire dbg_pkg::byte_strm_t rx_byte,
   input  wire logic                rx_break,
   input  wire logic                rx_error,
   input  wire logic [BPW-1:0]      bit_period,
   output dbg_pkg::byte_strm_t      tx_byte,
   input  wire logic                tx_ready,
   output dbg_pkg::bus_cmd_t        bus_cmd,
   input  wire logic                bus_ack,
   input  wire logic [15:0]         bus_rdata,
   output logic [63:0]              key_data,
   output logic                     key_valid,
   output logic                     error_state
);
   dbg_pkg::eng_state_t state_q, state_d;
   logic [7:0]          instr_q, instr_d;
   logic [4:0]          cnt_q, cnt_d;
   logic [15:0]         addr_q, addr_d;
   logic [63:0]         data_q, data_d;
   logic [15:0]         ptr_q, ptr_d;
   logic [7:0]          rpt_q, rpt_d;
   logic                rpt_arm_q, rpt_arm_d;
   logic [7:0]          rpt_left_q, rpt_left_d;
   logic [127:0]        txbuf_q, txbuf_d;
   logic [4:0]          txn_q, txn_d;
   logic                then_data_q, then_data_d;
   logic                err_seen_q, err_seen_d;
   logic                gt_start_q, gt_start_d;
   logic [7:0]          cs_q [16];
   logic [7:0]          cs_d [16];
   dbg_pkg::byte_strm_t tx_q, tx_d;
   dbg_pkg::bus_cmd_t   bus_q, bus_d;
   logic [63:0]         key_q, key_d;
   logic                key_v_q, key_v_d;
   logic                err_q, err_d;
   logic                gt_done;
   logic [2:0]          op;
   logic [1:0]          asz;
   logic [1:0]          dsz;
   logic                finish;
   logic                launch;
   logic [4:0]          need;

   function automatic logic [4:0] nbytes(input logic [1:0] sz);
      return (sz == dbg_pkg::SZ_WORD) ? 5'h02 : 5'h01;
   endfunction : nbytes

   function automatic logic bad_size(input logic [1:0] sz);
      return (sz != dbg_pkg::SZ_BYTE) && (sz != dbg_pkg::SZ_WORD);
   endfunction : bad_size

   function automatic logic [7:0] guard_bits(input logic [2:0] g);
      return (g == dbg_pkg::GUARD_NONE) ? 8'h00 : (dbg_pkg::GUARD_MAX >> g);
   endfunction : guard_bits

   guard_timer #(
      .CW (BPW)
   ) u_guard (
      .clk        (clk),
      .resetn     (resetn),
      .start      (gt_start_q),
      .idle_bits  (guard_bits(cs_q[dbg_pkg::CS_CTRL_A][2:0])), // R1 R3
      .bit_period (bit_period),
      .done       (gt_done)
   );

   assign op  = instr_q[dbg_pkg::OP_MSB:dbg_pkg::OP_LSB]; // R24
   assign asz = instr_q[dbg_pkg::ASZ_LSB +: 2];
   assign dsz = instr_q[dbg_pkg::DSZ_LSB +: 2];

   always_comb begin
      state_d     = state_q;
      instr_d     = instr_q;
      cnt_d       = cnt_q;
      addr_d      = addr_q;
      data_d      = data_q;
      ptr_d       = ptr_q;
      rpt_d       = rpt_q;
      rpt_arm_d   = rpt_arm_q;
      rpt_left_d  = rpt_left_q;
      txbuf_d     = txbuf_q;
      txn_d       = txn_q;
      then_data_d = then_data_q;
      err_seen_d  = err_seen_q;
      gt_start_d  = 1'b0;
      cs_d        = cs_q;
      tx_d        = tx_q;
      bus_d       = bus_q;
      key_d       = key_q;
      key_v_d     = 1'b0;
      finish      = 1'b0;
      launch      = 1'b0;
      need        = 5'h01;
      case (state_q)
         dbg_pkg::ST_SYNC: begin
            if (rx_byte.valid) begin
               state_d = (rx_byte.data == dbg_pkg::SYNC_CHAR) ?
                         dbg_pkg::ST_INSTR : dbg_pkg::ST_ERR; // R5 R23
            end
         end
         dbg_pkg::ST_INSTR: begin
            if (rx_byte.valid) begin
               instr_d = rx_byte.data;
               state_d = dbg_pkg::ST_LAUNCH;
               if (rpt_arm_q) begin
                  rpt_arm_d  = 1'b0;
                  rpt_left_d = (rx_byte.data[7:5] == dbg_pkg::OP_REPEAT) ?
                               8'h00 : rpt_q; // R15 R16
               end
            end
         end
         dbg_pkg::ST_LAUNCH: begin
            cnt_d       = 5'h00;
            then_data_d = 1'b0;
            state_d     = dbg_pkg::ST_DATA;
            case (op)
               dbg_pkg::OP_DIRECT_LD, dbg_pkg::OP_DIRECT_ST: begin
                  state_d = (bad_size(asz) || bad_size(dsz)) ?
                            dbg_pkg::ST_ERR : dbg_pkg::ST_ADDR; // R25 R7
               end
               dbg_pkg::OP_INDIRECT_LD: begin
                  if (bad_size(dsz) || asz == 2'h3) begin
                     state_d = dbg_pkg::ST_ERR; // R25
                  end else if (asz == dbg_pkg::PTR_WRITE) begin
                     txbuf_d    = {112'h0, ptr_q}; // R9
                     txn_d      = nbytes(dsz);
                     gt_start_d = 1'b1;
                     state_d    = dbg_pkg::ST_GUARD;
                  end else begin
                     bus_d = '{1'b1, 1'b0, dsz[0], ptr_q, 16'h0}; // R9 R19
                     gt_start_d = 1'b1;
                     state_d    = dbg_pkg::ST_BUS;
                  end
               end
               dbg_pkg::OP_INDIRECT_ST: begin
                  if (bad_size(dsz) || asz == 2'h3) begin
                     state_d = dbg_pkg::ST_ERR; // R25
                  end else if (asz == dbg_pkg::PTR_WRITE) begin
                     state_d = dbg_pkg::ST_ADDR; // R10
                  end
               end
               dbg_pkg::OP_CS_LD: begin
                  txbuf_d    = {120'h0, cs_q[instr_q[3:0]]}; // R13
                  if (instr_q[3:0] == dbg_pkg::CS_STATUS) begin
                     txbuf_d[1:0] = {rpt_arm_q, err_seen_q};
                     err_seen_d   = 1'b0;
                  end
                  txn_d      = 5'h01;
                  gt_start_d = 1'b1;
                  state_d    = dbg_pkg::ST_GUARD;
               end
               dbg_pkg::OP_REPEAT: begin
                  if (dsz != dbg_pkg::SZ_BYTE) begin
                     state_d = dbg_pkg::ST_ERR; // R15
                  end
               end
               dbg_pkg::OP_KEY: begin
                  if (bad_size(dsz)) begin
                     state_d = dbg_pkg::ST_ERR;
                  end else if (instr_q[dbg_pkg::SIB_SEL_BIT]) begin
                     txbuf_d    = SIB_DATA; // R21
                     txn_d      = (dsz == dbg_pkg::SZ_WORD) ?
                                  dbg_pkg::SIB_BYTES_L : dbg_pkg::SIB_BYTES_S;
                     gt_start_d = 1'b1;
                     state_d    = dbg_pkg::ST_GUARD;
                  end else if (dsz != dbg_pkg::SZ_BYTE) begin
                     state_d = dbg_pkg::ST_ERR; // R20
                  end
               end
               default: begin
                  state_d = dbg_pkg::ST_DATA;
               end
            endcase
         end
         dbg_pkg::ST_ADDR: begin
            need = nbytes((op == dbg_pkg::OP_INDIRECT_ST) ? dsz : asz); // R6
            if (rx_byte.valid) begin
               addr_d[{cnt_q[0], 3'b000} +: 8] = rx_byte.data;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q + 5'h01 == need) begin
                  if (need == 5'h01) begin
                     addr_d[15:8] = 8'h00;
                  end
                  cnt_d      = 5'h00;
                  gt_start_d = 1'b1;
                  if (op == dbg_pkg::OP_DIRECT_LD) begin
                     bus_d   = '{1'b1, 1'b0, dsz[0], addr_d, 16'h0}; // R6
                     state_d = dbg_pkg::ST_BUS;
                  end else begin
                     if (op == dbg_pkg::OP_INDIRECT_ST) begin
                        ptr_d = addr_d; // R10
                     end else begin
                        then_data_d = 1'b1; // R8
                     end
                     txbuf_d = {120'h0, dbg_pkg::ACK_CHAR};
                     txn_d   = 5'h01;
                     state_d = dbg_pkg::ST_GUARD;
                  end
               end
            end
         end
         dbg_pkg::ST_DATA: begin
            case (op)
               dbg_pkg::OP_CS_ST, dbg_pkg::OP_REPEAT: need = 5'h01;
               dbg_pkg::OP_KEY: need = dbg_pkg::KEY_BYTES;
               default: need = nbytes(dsz);
            endcase
            if (rx_byte.valid) begin
               data_d[{cnt_q[2:0], 3'b000} +: 8] = rx_byte.data;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q + 5'h01 == need) begin
                  cnt_d = 5'h00;
                  case (op)
                     dbg_pkg::OP_CS_ST: begin
                        cs_d[instr_q[3:0]] = rx_byte.data; // R14
                        finish = 1'b1;
                     end
                     dbg_pkg::OP_REPEAT: begin
                        rpt_d     = rx_byte.data; // R15
                        rpt_arm_d = 1'b1;
                        finish    = 1'b1;
                     end
                     dbg_pkg::OP_KEY: begin
                        key_d   = data_d; // R20
                        key_v_d = 1'b1;
                        finish  = 1'b1;
                     end
                     default: begin
                        bus_d      = '{1'b1, 1'b1, dsz[0],
                                       (op == dbg_pkg::OP_DIRECT_ST) ?
                                       addr_q : ptr_q,
                                       (dsz == dbg_pkg::SZ_WORD) ?
                                       data_d[15:0] : {8'h00, data_d[7:0]}};
                        gt_start_d = 1'b1;
                        state_d    = dbg_pkg::ST_BUS; // R8 R12
                     end
                  endcase
               end
            end
         end
         dbg_pkg::ST_BUS: begin
            if (bus_ack) begin
               bus_d.req = 1'b0;
               txn_d     = bus_q.we ? 5'h01 : nbytes(dsz);
               txbuf_d   = bus_q.we ? {120'h0, dbg_pkg::ACK_CHAR} :
                           {112'h0, bus_q.word ? bus_rdata :
                                    {8'h00, bus_rdata[7:0]}};
               if ((op == dbg_pkg::OP_INDIRECT_LD ||
                    op == dbg_pkg::OP_INDIRECT_ST) &&
                   asz == dbg_pkg::PTR_INC) begin
                  ptr_d = ptr_q + {11'h0, nbytes(dsz)}; // R9 R11
               end
               state_d = dbg_pkg::ST_GUARD; // R4
            end
         end
         dbg_pkg::ST_GUARD: begin
            if (gt_done && !gt_start_q) begin
               state_d = dbg_pkg::ST_TX; // R1 R4
            end
         end
         dbg_pkg::ST_TX: begin
            if (!tx_q.valid) begin
               tx_d = '{1'b1, txbuf_q[7:0]};
            end else if (tx_ready) begin
               tx_d.valid = 1'b0;
               txbuf_d    = {8'h00, txbuf_q[127:8]};
               txn_d      = txn_q - 5'h01;
               if (txn_q == 5'h01) begin
                  if (then_data_q) begin
                     then_data_d = 1'b0;
                     state_d     = dbg_pkg::ST_DATA; // R8
                  end else begin
                     finish = 1'b1;
                  end
               end
            end
         end
         dbg_pkg::ST_ERR: begin
            err_seen_d = 1'b1; // R22
         end
         default: begin
            state_d = dbg_pkg::ST_ERR;
         end
      endcase
      if (finish) begin
         if (rpt_left_q != 8'h00) begin
            rpt_left_d = rpt_left_q - 8'h01; // R16 R17
            launch     = 1'b1;
         end
         state_d = launch ? dbg_pkg::ST_LAUNCH : dbg_pkg::ST_SYNC;
      end
      if (rx_error && !rx_break) begin
         state_d   = dbg_pkg::ST_ERR; // R22
         bus_d.req = 1'b0;
         tx_d      = '{1'b0, 8'h00};
      end
      if (rx_break) begin
         state_d     = dbg_pkg::ST_SYNC; // R18 R22
         rpt_arm_d   = 1'b0;
         rpt_left_d  = 8'h00;
         then_data_d = 1'b0;
         cnt_d       = 5'h00;
         bus_d.req   = 1'b0;
         tx_d        = '{1'b0, 8'h00};
      end
      err_d = (state_d == dbg_pkg::ST_ERR);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= dbg_pkg::ST_SYNC;
         instr_q     <= 8'h00;
         cnt_q       <= 5'h00;
         addr_q      <= 16'h0000;
         data_q      <= 64'h0;
         ptr_q       <= 16'h0000;
         rpt_q       <= 8'h00;
         rpt_arm_q   <= 1'b0;
         rpt_left_q  <= 8'h00;
         txbuf_q     <= 128'h0;
         txn_q       <= 5'h00;
         then_data_q <= 1'b0;
         err_seen_q  <= 1'b0;
         gt_start_q  <= 1'b0;
         for (int i = 0; i < 16; i++) begin
            cs_q[i] <= (4'(i) == dbg_pkg::CS_CTRL_A) ?
                       dbg_pkg::CTRL_A_RST : 8'h00;
         end
         tx_q        <= '{1'b0, 8'h00};
         bus_q       <= '0;
         key_q       <= 64'h0;
         key_v_q     <= 1'b0;
         err_q       <= 1'b0;
      end else begin
         state_q     <= state_d;
         instr_q     <= instr_d;
         cnt_q       <= cnt_d;
         addr_q      <= addr_d;
         data_q      <= data_d;
         ptr_q       <= ptr_d;
         rpt_q       <= rpt_d;
         rpt_arm_q   <= rpt_arm_d;
         rpt_left_q  <= rpt_left_d;
         txbuf_q     <= txbuf_d;
         txn_q       <= txn_d;
         then_data_q <= then_data_d;
         err_seen_q  <= err_seen_d;
         gt_start_q  <= gt_start_d;
         cs_q        <= cs_d;
         tx_q        <= tx_d;
         bus_q       <= bus_d;
         key_q       <= key_d;
         key_v_q     <= key_v_d;
         err_q       <= err_d;
      end
   end

   assign tx_byte     = tx_q;
   assign bus_cmd     = bus_q;
   assign key_data    = key_q;
   assign key_valid   = key_v_q;
   assign error_state = err_q;
endmodule : dbg_engine

// >>> logic/dbg_pkg.sv
// shared constants and types of the single-pin debug instruction engine
package dbg_pkg;
   localparam logic [7:0] SYNC_CHAR     = 8'h55;
   localparam logic [7:0] ACK_CHAR      = 8'h40;
   // opcode in bits 7:5 of an instruction byte
   localparam int         OP_MSB        = 7;
   localparam int         OP_LSB        = 5;
   localparam logic [2:0] OP_DIRECT_LD  = 3'h0;
   localparam logic [2:0] OP_INDIRECT_LD = 3'h1;
   localparam logic [2:0] OP_DIRECT_ST  = 3'h2;
   localparam logic [2:0] OP_INDIRECT_ST = 3'h3;
   localparam logic [2:0] OP_CS_LD      = 3'h4;
   localparam logic [2:0] OP_REPEAT     = 3'h5;
   localparam logic [2:0] OP_CS_ST      = 3'h6;
   localparam logic [2:0] OP_KEY        = 3'h7;
   // address size or pointer mode in 3:2, data size in 1:0
   localparam int         ASZ_LSB       = 2;
   localparam int         DSZ_LSB       = 0;
   localparam int         SIB_SEL_BIT   = 2;
   localparam logic [1:0] SZ_BYTE       = 2'h0;
   localparam logic [1:0] SZ_WORD       = 2'h1;
   localparam logic [1:0] PTR_KEEP      = 2'h0;
   localparam logic [1:0] PTR_INC       = 2'h1;
   localparam logic [1:0] PTR_WRITE     = 2'h2;
   localparam logic [4:0] KEY_BYTES     = 5'h08;
   localparam logic [4:0] SIB_BYTES_S   = 5'h08;
   localparam logic [4:0] SIB_BYTES_L   = 5'h10;
   // control/status space
   localparam logic [3:0] CS_STATUS     = 4'h1;
   localparam logic [3:0] CS_CTRL_A     = 4'h2;
   localparam int         GUARD_LSB     = 0;
   localparam logic [7:0] CTRL_A_RST    = 8'h00;
   localparam logic [2:0] GUARD_NONE    = 3'h7;
   localparam logic [7:0] GUARD_MAX     = 8'h80;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_strm_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_cmd_t;

   typedef enum logic [8:0] {
      ST_SYNC   = 9'h001,
      ST_INSTR  = 9'h002,
      ST_LAUNCH = 9'h004,
      ST_ADDR   = 9'h008,
      ST_DATA   = 9'h010,
      ST_BUS    = 9'h020,
      ST_GUARD  = 9'h040,
      ST_TX     = 9'h080,
      ST_ERR    = 9'h100
   } eng_state_t;
endpackage : dbg_pkg

// >>> logic/guard_timer.sv
// guard idle-bit timer counting whole bit periods
`timescale 1ns/1ns
module guard_timer #(
   parameter int CW = 16
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          start,
   input  wire logic [7:0]    idle_bits,
   input  wire logic [CW-1:0] bit_period,
   output logic               done
);
   logic [7:0]    bits_q, bits_d;
   logic [CW-1:0] cyc_q, cyc_d;
   logic          done_q, done_d;

   always_comb begin
      bits_d = bits_q;
      cyc_d  = cyc_q;
      done_d = done_q;
      if (start) begin
         bits_d = idle_bits;
         cyc_d  = bit_period;
         done_d = (idle_bits == 8'h00);
      end else if (!done_q) begin
         if (cyc_q <= CW'(1)) begin
            cyc_d = bit_period; // R2
            if (bits_q <= 8'h01) begin
               done_d = 1'b1;
            end else begin
               bits_d = bits_q - 8'h01;
            end
         end else begin
            cyc_d = cyc_q - CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bits_q <= 8'h00;
         cyc_q  <= '0;
         done_q <= 1'b1;
      end else begin
         bits_q <= bits_d;
         cyc_q  <= cyc_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;
endmodule : guard_timer

// >>> dv/dbg_engine_props.sv
// port assertions for the debug instruction engine
`timescale 1ns/1ns
module dbg_engine_props (
   input wire logic                clk,
   input wire logic                resetn,
   input wire dbg_pkg::byte_strm_t rx_byte,
   input wire logic                rx_break,
   input wire logic                rx_error,
   input wire dbg_pkg::byte_strm_t tx_byte,
   input wire logic                tx_ready,
   input wire dbg_pkg::bus_cmd_t   bus_cmd,
   input wire logic                bus_ack,
   input wire logic                key_valid,
   input wire logic                error_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   bus_hold_a:
      assert property (bus_cmd.req && !bus_ack && !rx_break && !rx_error
         |=> bus_cmd.req && $stable(bus_cmd))
      else $error("bus request changed before ack");
   bus_gap_a:
      assert property (bus_cmd.req && bus_ack |=> !bus_cmd.req)
      else $error("bus request not released after ack");
   tx_hold_a:
      assert property (tx_byte.valid && !tx_ready && !rx_break && !rx_error
         |=> tx_byte.valid && $stable(tx_byte.data))
      else $error("tx byte changed before accept");
   tx_gap_a:
      assert property (tx_byte.valid && tx_ready |=> !tx_byte.valid)
      else $error("tx valid not dropped after accept");
   turn_guard_a:
      assert property ($rose(tx_byte.valid)
         |-> !$past(rx_byte.valid) && !$past(rx_byte.valid, 2))
      else $error("transmit started without turnaround");
   err_mute_a:
      assert property (error_state |-> !tx_byte.valid && !bus_cmd.req)
      else $error("activity while in error state");
   err_enter_a:
      assert property (rx_error && !rx_break |=> error_state)
      else $error("error state not entered");
   brk_clear_a:
      assert property (rx_break |=> !error_state)
      else $error("break did not clear error state");
   key_quiet_a:
      assert property (key_valid |=> (!key_valid && !tx_byte.valid) [*8])
      else $error("key pulse too long or answer sent");
endmodule : dbg_engine_props

// >>> dv/far_side_model.sv
// system bus memory and transmit acceptor model
`timescale 1ns/1ns
module far_side_model (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire dbg_pkg::bus_cmd_t bus_cmd,
   output logic                   bus_ack,
   output logic [15:0]            bus_rdata,
   output logic                   tx_ready
);
   logic [7:0] mem [256];
   logic [7:0] a;
   int         wait_q;
   assign a = bus_cmd.addr[7:0];
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_ack   <= 1'b0;
         bus_rdata <= 16'h0000;
         tx_ready  <= 1'b0;
         wait_q    <= 0;
      end else begin
         bus_ack   <= 1'b0;
         bus_rdata <= ~bus_rdata;
         tx_ready  <= ($urandom % 3) == 0;
         if (bus_cmd.req && !bus_ack) begin
            if (wait_q == 0) begin
               bus_ack   <= 1'b1;
               bus_rdata <= {mem[a + 8'h01], mem[a]};
               if (bus_cmd.we) begin
                  mem[a] <= bus_cmd.wdata[7:0];
                  if (bus_cmd.word)
                     mem[a + 8'h01] <= bus_cmd.wdata[15:8];
               end
               wait_q <= $urandom % 4;
            end else
               wait_q <= wait_q - 1;
         end
      end
   end
endmodule : far_side_model

// >>> dv/tb.sv
// self-checking bench for the debug instruction engine
`timescale 1ns/1ns
module tb;
   localparam int           BPW = 16;
   localparam logic [127:0] SYSTEM_INFO_BLOCK = 128'h0f1e2d3c4b5a6978; // arbitrary value
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   dbg_pkg::byte_strm_t rx_byte = '0;
   logic                rx_break = 1'b0;
   logic                rx_error = 1'b0;
   logic [BPW-1:0]      bit_period = 16'h0002;
   dbg_pkg::byte_strm_t tx_byte;
   dbg_pkg::bus_cmd_t   bus_cmd;
   logic                tx_ready, bus_ack, key_valid, error_state;
   logic [15:0]         bus_rdata;
   logic [63:0]         key_data, k;
   logic [7:0]          tq[$];
   logic [63:0]         kq[$];
   logic [7:0]          mem [256];
   logic [7:0]          al [4];
   logic [7:0]          a, d, e;
   int                  fail_count = 0;
   int                  checks = 0;
   always #20 clk = ~clk;
   dbg_engine #(.BPW(BPW), .SIB_DATA(SYSTEM_INFO_BLOCK)) dbg_engine_inst (
      .clk(clk), .resetn(resetn), .rx_byte(rx_byte), .rx_break(rx_break),
      .rx_error(rx_error), .bit_period(bit_period), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .key_data(key_data), .key_valid(key_valid),
      .error_state(error_state));
   far_side_model far_side_model_inst (
      .clk(clk), .resetn(resetn), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .tx_ready(tx_ready));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic sb(input logic [7:0] b);
      @(negedge clk);
      rx_byte = {1'b1, b};
      @(negedge clk);
      rx_byte = {1'b0, ~b};
   endtask : sb
   task automatic wt;
      for (int i = 0; i < 3000 && tq.size() > 0; i++)
         @(negedge clk);
      chk(tq.size(), 0);
      repeat (2) @(negedge clk);
   endtask : wt
   task automatic brk(input logic err);
      @(negedge clk);
      rx_error = err;
      rx_break = !err;
      @(negedge clk);
      rx_error = 1'b0;
      rx_break = 1'b0;
      repeat (2) @(negedge clk);
   endtask : brk
   task automatic finish_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // result watcher: every accepted byte or key must have been noted
   always @(posedge clk) begin
      if (tx_byte.valid === 1'b1 && tx_ready === 1'b1) begin
         chk(tq.size() != 0, 1);
         if (tq.size() != 0)
            chk(tx_byte.data, tq.pop_front());
      end
      if (key_valid === 1'b1) begin
         chk(kq.size() != 0, 1);
         if (kq.size() != 0)
            chk(key_data, kq.pop_front());
      end
   end
   initial begin
      #2000000;
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h724f));
      repeat (2) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      sb(8'h55);
      sb(8'hc2);
      sb(8'h06);
      sb(8'h55);
      sb(8'h82);
      tq.push_back(8'h06);
      wt();
      for (int i = 0; i < 4; i++) begin
         a = 8'($urandom % 127);
         d = 8'($urandom);
         e = 8'($urandom);
         al[i] = a;
         sb(8'h55);
         sb({7'h20, i[0]});
         sb(a);
         tq.push_back(dbg_pkg::ACK_CHAR);
         wt();
         sb(d);
         if (i[0]) sb(e);
         tq.push_back(dbg_pkg::ACK_CHAR);
         wt();
         mem[a] = d;
         if (i[0]) mem[a + 8'h01] = e;
         sb(8'h55);
         sb({7'h00, i[0]});
         sb(a);
         tq.push_back(d);
         if (i[0]) tq.push_back(e);
         wt();
      end
      sb(8'h55);
      sb(8'ha0);
      sb(8'h01);
      sb(8'h55);
      sb(8'h00);
      for (int j = 0; j < 2; j++) begin
         sb(al[j + 2]);
         tq.push_back(mem[al[j + 2]]);
         wt();
      end
      sb(8'h55);
      sb(8'h68);
      sb(8'hc0);
      tq.push_back(dbg_pkg::ACK_CHAR);
      wt();
      sb(8'h55);
      sb(8'ha0);
      sb(8'h02);
      sb(8'h55);
      sb(8'h64);
      for (int j = 0; j < 3; j++) begin
         d = 8'($urandom);
         mem[8'hc0 + j] = d;
         sb(d);
         tq.push_back(dbg_pkg::ACK_CHAR);
         wt();
      end
      sb(8'h55);
      sb(8'h28);
      tq.push_back(8'hc3);
      wt();
      sb(8'h55);
      sb(8'h68);
      sb(8'hc1);
      tq.push_back(dbg_pkg::ACK_CHAR);
      wt();
      sb(8'h55);
      sb(8'ha0);
      sb(8'h01);
      sb(8'h55);
      sb(8'h20);
      tq.push_back(mem[8'hc1]);
      tq.push_back(mem[8'hc1]);
      wt();
      sb(8'h55);
      sb(8'h24);
      tq.push_back(mem[8'hc1]);
      wt();
      sb(8'h55);
      sb(8'h20);
      tq.push_back(mem[8'hc2]);
      wt();
      k = {$urandom, $urandom};
      kq.push_back(k);
      sb(8'h55);
      sb(8'he0);
      for (int j = 0; j < 8; j++)
         sb(k[8*j +: 8]);
      repeat (10) @(negedge clk);
      chk(kq.size(), 0);
      sb(8'h55);
      sb(8'he4);
      for (int j = 0; j < 8; j++)
         tq.push_back(SYSTEM_INFO_BLOCK[8*j +: 8]);
      wt();
      sb(8'h55);
      sb(8'ha0);
      sb(8'h05);
      sb(8'h55);
      sb(8'h00);
      sb(al[0]);
      tq.push_back(mem[al[0]]);
      wt();
      brk(1'b0);
      sb(8'h12);
      repeat (2) @(negedge clk);
      chk(error_state, 1);
      sb(8'h55);
      sb(8'h82);
      repeat (8) @(negedge clk);
      brk(1'b0);
      chk(error_state, 0);
      brk(1'b1);
      chk(error_state, 1);
      brk(1'b0);
      sb(8'h55);
      sb(8'h81);
      tq.push_back(8'h01);
      wt();
      finish_test();
   end
endmodule : tb
bind dbg_engine dbg_engine_props dbg_engine_props_inst (
   .clk(clk), .resetn(resetn), .rx_byte(rx_byte), .rx_break(rx_break),
   .rx_error(rx_error), .tx_byte(tx_byte), .tx_ready(tx_ready),
   .bus_cmd(bus_cmd), .bus_ack(bus_ack), .key_valid(key_valid),
   .error_state(error_state));
